// [rtl/bre_pkg.sv]
package bre_pkg;

  // ------------------------------------------------------------------
  // Configuration space byte offsets.
  // ------------------------------------------------------------------
  localparam logic [7:0] BRE_OFF_CMD        = 8'h04;
  localparam logic [7:0] BRE_OFF_STATUS     = 8'h06;
  localparam logic [7:0] BRE_OFF_SEC_STATUS = 8'h1e;
  localparam logic [7:0] BRE_OFF_BRIDGE_CTL = 8'h3e;
  localparam logic [7:0] BRE_OFF_DIAG_CTL   = 8'h5c;
  localparam logic [7:0] BRE_OFF_ERR_MASK   = 8'h64;
  localparam logic [7:0] BRE_OFF_ERR_FLAGS  = 8'h6a;

  // ------------------------------------------------------------------
  // Field positions.
  // ------------------------------------------------------------------
  localparam int BRE_CMD_PERR_RESP   = 6;
  localparam int BRE_CMD_SERR_EN     = 8;
  localparam int BRE_STS_DPE_MASTER  = 8;
  localparam int BRE_STS_DET_PERR    = 15;
  localparam int BRE_SSTS_SIG_SERR   = 14;
  localparam int BRE_BCTL_SERR_FWD   = 1;
  localparam int BRE_BCTL_MABORT_MD  = 5;
  localparam int BRE_DIAG_PAR_GEN    = 14;

  // Error condition bits, shared by the mask and the flag registers.
  localparam int BRE_EV_PW_PARITY    = 1;
  localparam int BRE_EV_PW_TIMEOUT   = 2;
  localparam int BRE_EV_PW_TABORT    = 3;
  localparam int BRE_EV_PW_MABORT    = 4;
  localparam int BRE_EV_DW_TIMEOUT   = 5;
  localparam int BRE_EV_DR_TIMEOUT   = 6;
  localparam logic [7:0] BRE_EV_IMPL = 8'h7e;

  // ------------------------------------------------------------------
  // Reset values and widths.
  // ------------------------------------------------------------------
  localparam logic [15:0] BRE_RST_16 = 16'h0000;
  localparam logic [7:0]  BRE_RST_8  = 8'h00;
  localparam logic [31:0] BRE_RST_32 = 32'h0000_0000;
  localparam logic [2:0]  BRE_FUNC0  = 3'h0;

  typedef enum logic [1:0] {
    BRE_RD_IDLE,
    BRE_RD_DRAIN,
    BRE_RD_DISC
  } bre_rd_state_t;

endpackage : bre_pkg

// [rtl/bre_sticky.sv]
`timescale 1ns/1ps

// ---------------------------------------------------------------------
// Sticky flags: hardware sets, software clears by writing one.
// ---------------------------------------------------------------------
module bre_sticky #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  output logic      [W-1:0] flag_q
);

  logic [W-1:0] flag_d;

  // A set in the same cycle as a clear wins, so no event is lost.
  assign flag_d = set_i | (flag_q & ~clr_i);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule : bre_sticky

// [rtl/bre_error_report.sv]
`timescale 1ns/1ps

module bre_error_report
  import bre_pkg::*;
(
  clk_sys,
  sys_rst,
  cfg_req,
  cfg_type0,
  cfg_idsel,
  cfg_func,
  cfg_write,
  cfg_addr,
  cfg_be,
  cfg_wdata,
  cfg_claim,
  cfg_rvalid,
  cfg_rdata,
  ev_err,
  sec_serr_seen,
  addr_parity_err,
  data_parity_err,
  master_perr_seen,
  wr_burst_tabort,
  rd_burst_tabort,
  rd_data_left,
  prim_access_sec_rst,
  serr_o,
  serr_oe_n,
  perr_o,
  perr_oe_n,
  parity_generate,
  prim_target_abort,
  prim_ones_fill,
  rd_disconnect
);

  input  wire logic        clk_sys;
  input  wire logic        sys_rst;
  input  wire logic        cfg_req;
  input  wire logic        cfg_type0;
  input  wire logic        cfg_idsel;
  input  wire logic [2:0]  cfg_func;
  input  wire logic        cfg_write;
  input  wire logic [7:2]  cfg_addr;
  input  wire logic [3:0]  cfg_be;
  input  wire logic [31:0] cfg_wdata;
  output wire logic        cfg_claim;
  output logic             cfg_rvalid;
  output logic      [31:0] cfg_rdata;
  input  wire logic [7:0]  ev_err;
  input  wire logic        sec_serr_seen;
  input  wire logic        addr_parity_err;
  input  wire logic        data_parity_err;
  input  wire logic        master_perr_seen;
  input  wire logic        wr_burst_tabort;
  input  wire logic        rd_burst_tabort;
  input  wire logic        rd_data_left;
  input  wire logic        prim_access_sec_rst;
  output wire logic        serr_o;
  output logic             serr_oe_n;
  output wire logic        perr_o;
  output logic             perr_oe_n;
  output wire logic        parity_generate;
  output logic             prim_target_abort;
  output logic             prim_ones_fill;
  output wire logic        rd_disconnect;

  // -------------------------------------------------------------------
  // Configuration decode
  // -------------------------------------------------------------------
  logic [15:0] cmd_q;
  logic [15:0] bctl_q;
  logic [15:0] diag_q;
  logic [7:0]  mask_q;
  logic [15:0] status_q;
  logic [15:0] sec_status_q;
  logic [7:0]  flags_q;
  logic [31:0] rd_mux;

  wire hit_cmd  = cfg_addr == BRE_OFF_CMD[7:2];
  wire hit_sec  = cfg_addr == BRE_OFF_SEC_STATUS[7:2];
  wire hit_bctl = cfg_addr == BRE_OFF_BRIDGE_CTL[7:2];
  wire hit_diag = cfg_addr == BRE_OFF_DIAG_CTL[7:2];
  wire hit_mask = cfg_addr == BRE_OFF_ERR_MASK[7:2];
  wire hit_flag = cfg_addr == BRE_OFF_ERR_FLAGS[7:2];

  // Other functions stay unclaimed so the access ends in a master abort.
  assign cfg_claim = cfg_req & cfg_type0 & cfg_idsel & (cfg_func == BRE_FUNC0);
  wire   wr_ok     = cfg_claim & cfg_write;

  // Byte lane writes: each register sits in the lanes its offset names.
  wire [3:0] wr_cmd  = {4{wr_ok & hit_cmd}}  & cfg_be;
  wire [3:0] wr_sec  = {4{wr_ok & hit_sec}}  & cfg_be;
  wire [3:0] wr_bctl = {4{wr_ok & hit_bctl}} & cfg_be;
  wire [3:0] wr_diag = {4{wr_ok & hit_diag}} & cfg_be;
  wire [3:0] wr_mask = {4{wr_ok & hit_mask}} & cfg_be;
  wire [3:0] wr_flag = {4{wr_ok & hit_flag}} & cfg_be;

  wire [15:0] wd_lo = cfg_wdata[15:0];
  wire [15:0] wd_hi = cfg_wdata[31:16];

  // -------------------------------------------------------------------
  // Writable control registers
  // -------------------------------------------------------------------
  logic [15:0] cmd_d;
  logic [15:0] bctl_d;
  logic [15:0] diag_d;
  logic [7:0]  mask_d;

  // Only the bits this block acts on are kept; the rest read as zero.
  assign cmd_d[15:9]  = '0;
  assign cmd_d[8]     = wr_cmd[1] ? wd_lo[BRE_CMD_SERR_EN] : cmd_q[8];
  assign cmd_d[7]     = 1'b0;
  assign cmd_d[6]     = wr_cmd[0] ? wd_lo[BRE_CMD_PERR_RESP] : cmd_q[6];
  assign cmd_d[5:0]   = '0;
  assign bctl_d[15:6] = '0;
  assign bctl_d[5]    = wr_bctl[2] ? wd_hi[BRE_BCTL_MABORT_MD] : bctl_q[5];
  assign bctl_d[4:2]  = '0;
  assign bctl_d[1]    = wr_bctl[2] ? wd_hi[BRE_BCTL_SERR_FWD] : bctl_q[1];
  assign bctl_d[0]    = 1'b0;
  assign diag_d[15]   = 1'b0;
  assign diag_d[14]   = wr_diag[1] ? wd_lo[BRE_DIAG_PAR_GEN] : diag_q[14];
  assign diag_d[13:0] = '0;
  assign mask_d       = wr_mask[0] ? (cfg_wdata[7:0] & BRE_EV_IMPL) : mask_q;

  // Every condition starts enabled, and reporting starts off.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_q  <= BRE_RST_16;
      bctl_q <= BRE_RST_16;
      diag_q <= BRE_RST_16;
      mask_q <= BRE_RST_8;
    end else begin
      cmd_q  <= cmd_d;
      bctl_q <= bctl_d;
      diag_q <= diag_d;
      mask_q <= mask_d;
    end
  end

  assign parity_generate = diag_q[BRE_DIAG_PAR_GEN];

  // -------------------------------------------------------------------
  // Error conditions
  // -------------------------------------------------------------------
  wire serr_en  = cmd_q[BRE_CMD_SERR_EN];
  wire perr_rsp = cmd_q[BRE_CMD_PERR_RESP];

  // Flags record an enabled condition even while reporting is off, so
  // software can still see what happened after enabling late.
  wire [7:0] ev_live = ev_err & ~mask_q & BRE_EV_IMPL;

  wire fwd_serr = sec_serr_seen & bctl_q[BRE_BCTL_SERR_FWD];
  wire par_serr = perr_rsp & (addr_parity_err | wr_burst_tabort
                             | rd_burst_tabort);
  wire serr_req = serr_en & ((|ev_live) | fwd_serr | par_serr);

  // -------------------------------------------------------------------
  // Open-drain error outputs
  // -------------------------------------------------------------------
  assign serr_o = 1'b0;
  assign perr_o = 1'b0;

  // The enable is registered, so the pin goes low one clock after the request and stays low while it lasts.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      serr_oe_n <= 1'b1;
      perr_oe_n <= 1'b1;
    end else begin
      serr_oe_n <= ~serr_req;
      perr_oe_n <= ~(perr_rsp & data_parity_err);
    end
  end

  // -------------------------------------------------------------------
  // Status flags
  // -------------------------------------------------------------------
  logic [1:0] sts_set;
  logic [1:0] sts_clr;
  logic [1:0] sts_q;

  assign sts_set[1] = addr_parity_err | data_parity_err;
  assign sts_set[0] = perr_rsp & (data_parity_err | master_perr_seen);
  assign sts_clr[1] = wr_cmd[3] & wd_hi[BRE_STS_DET_PERR];
  assign sts_clr[0] = wr_cmd[3] & wd_hi[BRE_STS_DPE_MASTER];

  bre_sticky #(.W(2)) u_status (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .set_i   (sts_set),
    .clr_i   (sts_clr),
    .flag_q  (sts_q)
  );

  logic sig_serr_q;

  bre_sticky #(.W(1)) u_sec_status (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .set_i   (serr_req),
    .clr_i   (wr_sec[3] & wd_hi[BRE_SSTS_SIG_SERR]),
    .flag_q  (sig_serr_q)
  );

  // Writing zero leaves a flag alone; writing one clears it.
  bre_sticky #(.W(8)) u_flags (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .set_i   (ev_live),
    .clr_i   ({8{wr_flag[2]}} & cfg_wdata[23:16]),
    .flag_q  (flags_q)
  );

  always_comb begin
    status_q                     = BRE_RST_16;
    status_q[BRE_STS_DET_PERR]   = sts_q[1];
    status_q[BRE_STS_DPE_MASTER] = sts_q[0];
    sec_status_q                 = BRE_RST_16;
    sec_status_q[BRE_SSTS_SIG_SERR] = sig_serr_q;
  end

  // -------------------------------------------------------------------
  // Abort handling toward the initiator
  // -------------------------------------------------------------------
  wire mabort_mode = bctl_q[BRE_BCTL_MABORT_MD];

  // With abort mode set the initiator gets a target abort; otherwise
  // reads return all ones and writes are quietly completed.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prim_target_abort <= 1'b0;
      prim_ones_fill    <= 1'b0;
    end else begin
      prim_target_abort <= wr_burst_tabort
                           | (prim_access_sec_rst & mabort_mode);
      prim_ones_fill    <= prim_access_sec_rst & ~mabort_mode;
    end
  end

  bre_rd_state_t rd_st_q;
  bre_rd_state_t rd_st_d;

  // A read abort keeps delivering fetched data and then disconnects.
  always_comb begin
    rd_st_d = rd_st_q;
    case (rd_st_q)
      BRE_RD_IDLE: begin
        if (rd_burst_tabort) begin
          rd_st_d = rd_data_left ? BRE_RD_DRAIN : BRE_RD_DISC;
        end
      end
      BRE_RD_DRAIN: begin
        if (!rd_data_left) begin
          rd_st_d = BRE_RD_DISC;
        end
      end
      BRE_RD_DISC: begin
        rd_st_d = BRE_RD_IDLE;
      end
      default: begin
        rd_st_d = BRE_RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rd_st_q <= BRE_RD_IDLE;
    end else begin
      rd_st_q <= rd_st_d;
    end
  end

  assign rd_disconnect = rd_st_q == BRE_RD_DISC;

  // -------------------------------------------------------------------
  // Read data
  // -------------------------------------------------------------------
  wire [31:0] rd_cmd  = {status_q, cmd_q};
  wire [31:0] rd_sec  = {sec_status_q, BRE_RST_16};
  wire [31:0] rd_bctl = {bctl_q, BRE_RST_16};
  wire [31:0] rd_diag = {BRE_RST_16, diag_q};
  wire [31:0] rd_mask = {BRE_RST_16, BRE_RST_8, mask_q};
  wire [31:0] rd_flag = {BRE_RST_8, flags_q, BRE_RST_16};

  // Unmapped words read as zero.
  assign rd_mux = hit_cmd  ? rd_cmd  :
                  hit_sec  ? rd_sec  :
                  hit_bctl ? rd_bctl :
                  hit_diag ? rd_diag :
                  hit_mask ? rd_mask :
                  hit_flag ? rd_flag : BRE_RST_32;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_rvalid <= 1'b0;
      cfg_rdata  <= BRE_RST_32;
    end else begin
      cfg_rvalid <= cfg_claim & ~cfg_write;
      if (cfg_claim & ~cfg_write) begin
        cfg_rdata <= rd_mux;
      end
    end
  end

endmodule : bre_error_report

// [verif/bre_error_report_chk.sv]
`timescale 1ns/1ps
module bre_error_report_chk
  import bre_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic       cfg_req,
  input wire logic       cfg_type0,
  input wire logic       cfg_idsel,
  input wire logic [2:0] cfg_func,
  input wire logic       cfg_write,
  input wire logic       cfg_claim,
  input wire logic       cfg_rvalid,
  input wire logic [7:0] ev_err,
  input wire logic       sec_serr_seen,
  input wire logic       addr_parity_err,
  input wire logic       data_parity_err,
  input wire logic       wr_burst_tabort,
  input wire logic       rd_burst_tabort,
  input wire logic       rd_data_left,
  input wire logic       prim_access_sec_rst,
  input wire logic       serr_o,
  input wire logic       serr_oe_n,
  input wire logic       perr_oe_n,
  input wire logic       prim_target_abort,
  input wire logic       prim_ones_fill,
  input wire logic       rd_disconnect
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic cause_q;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) cause_q <= 1'b0;
    else cause_q <= (|ev_err[6:1]) | sec_serr_seen | addr_parity_err | wr_burst_tabort
                    | rd_burst_tabort;
  end
  sequence s_rd_taken;
    cfg_claim && !cfg_write;
  endsequence
  sequence s_abort_drained;
    rd_burst_tabort && !rd_data_left;
  endsequence
  a_claim_decode: assert property (
    cfg_claim == (cfg_req && cfg_type0 && cfg_idsel && cfg_func == 3'h0))
    else $error("claim decode wrong");
  a_read_answer: assert property (s_rd_taken |=> cfg_rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (cfg_rvalid |-> $past(cfg_claim) && !$past(cfg_write))
    else $error("stray read valid");
  a_serr_cause: assert property (!serr_oe_n |-> cause_q)
    else $error("system error without cause");
  a_open_drain: assert property (serr_o == 1'b0)
    else $error("system error data not low");
  a_perr_cause: assert property (!perr_oe_n |-> $past(data_parity_err))
    else $error("parity error without bad data");
  a_wr_abort: assert property (wr_burst_tabort |=> prim_target_abort)
    else $error("write abort not returned");
  a_abort_mode: assert property (
    prim_access_sec_rst |-> ##1 (prim_target_abort != prim_ones_fill))
    else $error("no single abort report");
  a_fill_cause: assert property (prim_ones_fill |-> $past(prim_access_sec_rst))
    else $error("stray quiet completion");
  a_disc_drained: assert property (s_abort_drained |=> rd_disconnect)
    else $error("no disconnect after drain");
  a_disc_waits: assert property (rd_disconnect |-> !$past(rd_data_left))
    else $error("disconnect with data left");
endmodule : bre_error_report_chk

bind bre_error_report bre_error_report_chk i_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_req(cfg_req), .cfg_type0(cfg_type0),
  .cfg_idsel(cfg_idsel), .cfg_func(cfg_func), .cfg_write(cfg_write), .cfg_claim(cfg_claim),
  .cfg_rvalid(cfg_rvalid), .ev_err(ev_err), .sec_serr_seen(sec_serr_seen),
  .addr_parity_err(addr_parity_err), .data_parity_err(data_parity_err),
  .wr_burst_tabort(wr_burst_tabort), .rd_burst_tabort(rd_burst_tabort),
  .rd_data_left(rd_data_left), .prim_access_sec_rst(prim_access_sec_rst), .serr_o(serr_o),
  .serr_oe_n(serr_oe_n), .perr_oe_n(perr_oe_n), .prim_target_abort(prim_target_abort),
  .prim_ones_fill(prim_ones_fill), .rd_disconnect(rd_disconnect));

// [verif/bre_far_side.sv]
`timescale 1ns/1ps
module bre_far_side (
  input  wire logic       clk_sys,
  input  wire logic       serr_o,
  input  wire logic       serr_oe_n,
  output wire logic [7:0] ev_err,
  output wire logic       sec_serr_seen,
  output wire logic       addr_parity_err,
  output wire logic       data_parity_err,
  output wire logic       master_perr_seen,
  output wire logic       wr_burst_tabort,
  output wire logic       rd_burst_tabort,
  output wire logic       prim_access_sec_rst,
  output logic            rd_data_left,
  output wire logic       serr_line
);
  logic [14:0] pulse_q = 15'h0000;
  initial rd_data_left = 1'b0;
  assign {prim_access_sec_rst, rd_burst_tabort, wr_burst_tabort, master_perr_seen,
          data_parity_err, addr_parity_err, sec_serr_seen, ev_err} = pulse_q;
  // The shared wire has a pull-up, so a released driver reads high.
  assign serr_line = serr_oe_n ? 1'b1 : serr_o;
  // A held level keeps fetched read data pending, so the drain can be slow.
  task put(input logic [14:0] v, input logic hold);
    @(negedge clk_sys);
    pulse_q = v;
    rd_data_left = hold;
    @(negedge clk_sys);
    pulse_q = 15'h0000;
  endtask : put
  task drained;
    rd_data_left = 1'b0;
  endtask : drained
endmodule : bre_far_side

// [verif/bre_error_report_test.sv]
`timescale 1ns/1ps
module bre_error_report_test;
  import bre_pkg::*;
  logic        clk_sys, sys_rst, cfg_req, cfg_type0, cfg_idsel, cfg_write, master_perr_seen;
  logic [2:0]  cfg_func;
  logic [7:2]  cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [7:0]  ev_err;
  logic        sec_serr_seen, addr_parity_err, data_parity_err, wr_burst_tabort;
  logic        rd_burst_tabort, rd_data_left, prim_access_sec_rst, cfg_claim, cfg_rvalid;
  logic        serr_o, serr_oe_n, perr_o, perr_oe_n, parity_generate, prim_target_abort;
  logic        prim_ones_fill, rd_disconnect, serr_line;
  int          err_count, num_checks, cmd, sts, ssts, bctl, diag, mask, flags;
  int          adrs[6] = '{32'h0000_0004, 32'h0000_001c, 32'h0000_003c, 32'h0000_005c,
                           32'h0000_0064, 32'h0000_0068};

  bre_error_report i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_req(cfg_req),
    .cfg_type0(cfg_type0), .cfg_idsel(cfg_idsel), .cfg_func(cfg_func), .cfg_write(cfg_write),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_claim(cfg_claim),
    .cfg_rvalid(cfg_rvalid), .cfg_rdata(cfg_rdata), .ev_err(ev_err),
    .sec_serr_seen(sec_serr_seen), .addr_parity_err(addr_parity_err),
    .data_parity_err(data_parity_err), .master_perr_seen(master_perr_seen),
    .wr_burst_tabort(wr_burst_tabort), .rd_burst_tabort(rd_burst_tabort),
    .rd_data_left(rd_data_left), .prim_access_sec_rst(prim_access_sec_rst), .serr_o(serr_o),
    .serr_oe_n(serr_oe_n), .perr_o(perr_o), .perr_oe_n(perr_oe_n),
    .parity_generate(parity_generate), .prim_target_abort(prim_target_abort),
    .prim_ones_fill(prim_ones_fill), .rd_disconnect(rd_disconnect));
  bre_far_side i_far (.clk_sys(clk_sys), .serr_o(serr_o), .serr_oe_n(serr_oe_n),
    .ev_err(ev_err), .sec_serr_seen(sec_serr_seen), .addr_parity_err(addr_parity_err),
    .data_parity_err(data_parity_err), .master_perr_seen(master_perr_seen),
    .wr_burst_tabort(wr_burst_tabort), .rd_burst_tabort(rd_burst_tabort),
    .prim_access_sec_rst(prim_access_sec_rst), .rd_data_left(rd_data_left),
    .serr_line(serr_line));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function int exp_rd(input int a);
    case (a)
      32'h0000_0004: return (sts << 16) | cmd;
      32'h0000_001c: return ssts << 16;
      32'h0000_003c: return bctl << 16;
      32'h0000_005c: return diag;
      32'h0000_0064: return mask;
      32'h0000_0068: return flags << 16;
      default: return 0;
    endcase
  endfunction : exp_rd

  task acc(input bit w, input int a, input int d, input int f);
    int k;
    @(negedge clk_sys);
    cfg_req = 1'b1;
    cfg_write = w;
    cfg_addr = a[7:2];
    cfg_wdata = d;
    cfg_func = f[2:0];
    #1 check(cfg_claim, f == 0);
    @(negedge clk_sys);
    cfg_req = 1'b0;
    check(cfg_rvalid, !w && f == 0);
    if (!w && f == 0) check(cfg_rdata, exp_rd(a));
    // Only the enabled byte lanes may change the model, as in the block.
    k = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
    d &= k;
    if (w && f == 0) begin
      case (a)
        32'h0000_0004: begin
          cmd = cmd & ~(k & 32'h0000_0140) | d & 32'h0000_0140;
          sts &= ~(d >> 16);
        end
        32'h0000_001c: ssts &= ~(d >> 16);
        32'h0000_003c: bctl = bctl & ~(k >> 16 & 32'h0000_0022) | d >> 16 & 32'h0000_0022;
        32'h0000_005c: diag = diag & ~(k & 32'h0000_4000) | d & 32'h0000_4000;
        32'h0000_0064: mask = mask & ~(k & 32'h0000_007e) | d & 32'h0000_007e;
        32'h0000_0068: flags &= ~(d >> 16);
        default: ;
      endcase
    end
  endtask : acc

  task ev(input int v, input bit h);
    int m;
    bit s;
    m = v & 32'h0000_007e & ~mask;
    s = cmd[8] && (m != 0 || v[8] && bctl[1] || cmd[6] && (v[9] || v[12] || v[13]));
    i_far.put(v[14:0], h);
    flags |= m;
    if (s) ssts |= 32'h0000_4000;
    if (v[9] || v[10]) sts |= 32'h0000_8000;
    if (cmd[6] && (v[10] || v[11])) sts |= 32'h0000_0100;
    check(serr_line, !s);
    check(perr_oe_n, !(cmd[6] && v[10]));
    check(perr_o, 1'b0);
    check(prim_target_abort, v[12] || v[14] && bctl[5]);
    check(prim_ones_fill, v[14] && !bctl[5]);
    check(rd_disconnect, v[13] && !h);
    @(negedge clk_sys);
    check(serr_line, 1'b1);
  endtask : ev

  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  initial begin
    {cfg_req, cfg_write, cfg_func, cfg_addr, cfg_wdata} = '0;
    {cfg_type0, cfg_idsel, cfg_be, sys_rst} = 7'h7f;
    void'($urandom(15));
    repeat (6) @(negedge clk_sys);
    sys_rst = 1'b0;
    foreach (adrs[i]) acc(0, adrs[i], 0, 0);
    check(parity_generate, 1'b0);
    ev(32'h0000_0008, 0);
    acc(1, 32'h0000_0068, 0, 0);
    acc(0, 32'h0000_0068, 0, 0);
    acc(1, 32'h0000_0068, 32'h0008_0000, 0);
    acc(0, 32'h0000_0068, 0, 0);
    acc(1, 32'h0000_0004, 32'h0000_0100, 0);
    for (int b = 1; b < 7; b++) ev(1 << b, 0);
    acc(0, 32'h0000_001c, 0, 0);
    acc(0, 32'h0000_0068, 0, 0);
    acc(1, 32'h0000_001c, 32'hffff_ffff, 0);
    repeat (20) begin
      acc(1, 32'h0000_0064, $urandom, 0);
      ev($urandom & 32'h0000_00ff, 0);
      acc(0, 32'h0000_0068, 0, 0);
    end
    acc(1, 32'h0000_0064, 0, 0);
    cfg_be = 4'he;
    acc(1, 32'h0000_0064, 32'h0000_007e, 0);
    acc(0, 32'h0000_0064, 0, 0);
    cfg_be = 4'hf;
    ev(32'h0000_0100, 0);
    acc(1, 32'h0000_003c, 32'h0002_0000, 0);
    ev(32'h0000_0100, 0);
    ev(32'h0000_0400, 0);
    acc(0, 32'h0000_0004, 0, 0);
    acc(1, 32'h0000_0004, 32'h0000_0140, 0);
    ev(32'h0000_0400, 0);
    acc(0, 32'h0000_0004, 0, 0);
    acc(1, 32'h0000_0004, 32'h8100_0140, 0);
    ev(32'h0000_0800, 0);
    ev(32'h0000_0200, 0);
    acc(0, 32'h0000_0004, 0, 0);
    acc(1, 32'h0000_0004, 32'hffff_0140, 0);
    acc(0, 32'h0000_0004, 0, 0);
    acc(1, 32'h0000_005c, 32'h0000_4000, 0);
    check(parity_generate, 1'b1);
    acc(0, 32'h0000_005c, 0, 0);
    ev(32'h0000_1000, 0);
    ev(32'h0000_4000, 0);
    acc(1, 32'h0000_003c, 32'h0022_0000, 0);
    ev(32'h0000_4000, 0);
    ev(32'h0000_2000, 0);
    ev(32'h0000_2000, 1);
    check(rd_disconnect, 1'b0);
    i_far.drained();
    @(negedge clk_sys);
    check(rd_disconnect, 1'b1);
    acc(0, 32'h0000_0004, 0, 1);
    acc(1, 32'h0000_00f0, 32'hffff_ffff, 0);
    acc(0, 32'h0000_00f0, 0, 0);
    sys_rst = 1'b1;
    @(negedge clk_sys);
    sys_rst = 1'b0;
    {cmd, sts, ssts, bctl, diag, mask, flags} = '0;
    foreach (adrs[i]) acc(0, adrs[i], 0, 0);
    give_verdict();
  end
endmodule : bre_error_report_test
